// ==== lbpe_pkg.sv ====
package lbpe_pkg;
   // ======================================================================
   // Register indices; the bus byte address is four times the index.
   // ======================================================================
   localparam logic [7:0] IDX_BEHAV_LOW = 8'h81;
   localparam logic [7:0] IDX_BEHAV_MID = 8'h82;
   localparam logic [7:0] IDX_BEHAV_HIGH = 8'h83;
   localparam logic [7:0] IDX_P1_PERIOD = 8'h84;
   localparam logic [7:0] IDX_P2_PERIOD = 8'h85;
   localparam logic [7:0] IDX_BR_PERIOD = 8'h86;
   localparam logic [7:0] IDX_CNT_CFG = 8'h88;
   localparam logic [7:0] IDX_L11_CFG = 8'h8a;
   localparam logic [7:0] IDX_CTRL = 8'hc0;
   localparam logic [7:0] IDX_STATUS = 8'hc1;

   // ======================================================================
   // Reset values and field positions.
   // ======================================================================
   localparam logic [7:0] RST_BEHAV = 8'h00;
   localparam logic [7:0] RST_P1_PERIOD = 8'h20;
   localparam logic [7:0] RST_P2_PERIOD = 8'h14;
   localparam logic [7:0] RST_BR_PERIOD = 8'h5d;
   localparam logic [7:0] RST_CNT_CFG = 8'h24;
   localparam logic [7:0] RST_L11_CFG = 8'h00;
   localparam int TRIG_SEL_BIT = 7;
   localparam int ALERT_EN_BIT = 6;
   localparam int VAR_PWM_BIT = 3;
   localparam int NUM_LED = 11;
   localparam int PER_W = 7;

   // ======================================================================
   // Timing: one period unit is 32 ms, counted in 1 ms ticks.
   // ======================================================================
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int UNIT_MS = 32;
   localparam int BASE_HZ = 500_000;
   localparam int BASE_DIV = CLK_HZ / BASE_HZ;

   typedef enum logic [1:0] {BH_DIRECT, BH_PULSE1, BH_PULSE2, BH_BREATHE} lbpe_mode_e;
   typedef enum logic [2:0] {ST_IDLE, ST_ON, ST_RAMP_UP, ST_RAMP_DN, ST_REST} lbpe_state_e;

   // Settings one channel needs from the register file.
   typedef struct packed {
      lbpe_mode_e mode;
      logic trig_on_release;
      logic [PER_W-1:0] pulse_one_period_field;
      logic [PER_W-1:0] pulse_two_period_field;
      logic [PER_W-1:0] breath_period_field;
      logic [2:0] p1_cnt;
      logic [2:0] p2_cnt;
      logic [7:0] steps_m1;
   } lbpe_cfg_s;
endpackage

// ==== lbpe_channel.sv ====
`timescale 1ns/10ps
// One LED channel: behaviour state machine and 8-bit brightness ramp.
module lbpe_channel
   import lbpe_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Timing.
   input wire logic tick_ms,
   input wire logic pwm_step,
   // Control.
   input wire lbpe_pkg::lbpe_cfg_s cfg,
   input wire logic actuate,
   input wire logic enable,
   // Results.
   output logic led_out,
   output logic done,
   output logic busy
);
   import lbpe_pkg::*;

   typedef struct packed {
      lbpe_state_e st;
      logic act_prev;
      logic releasing;
      logic [12:0] ms_cnt;
      logic [3:0] pulses;
      logic [7:0] level;
      logic [7:0] pwm_cnt;
      logic led;
      logic done;
   } lbpe_ch_s;

   lbpe_ch_s s_q, s_d;

   // Half a period in ms; codes 0 and 1 both give one 32 ms unit.
   function automatic logic [12:0] half_ms(input logic [PER_W-1:0] per);
      logic [12:0] units;
      units = (per == '0) ? 13'd1 : {6'd0, per};
      return 13'((units * 13'(UNIT_MS)) >> 1);
   endfunction

   logic [12:0] half_d;
   logic rise, fall, start_ev, stop_ev;

   always_comb
   begin
      case (cfg.mode)
         BH_PULSE1: half_d = half_ms(cfg.pulse_one_period_field);
         BH_PULSE2: half_d = half_ms(cfg.pulse_two_period_field);
         default: half_d = half_ms(cfg.breath_period_field);
      endcase
   end

   // A drive-bit set or touch is a rising edge; a clear or release is falling.
   assign rise = actuate & ~s_q.act_prev;
   assign fall = ~actuate & s_q.act_prev;
   assign start_ev = (cfg.mode == BH_PULSE1) ? (cfg.trig_on_release ? fall : rise) : rise;
   assign stop_ev = fall;

   // Next state; the ramp level follows elapsed ms within each half period.
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.act_prev = actuate;
      if (tick_ms && (s_q.st == ST_RAMP_UP || s_q.st == ST_RAMP_DN))
         s_d.ms_cnt = s_q.ms_cnt + 13'd1;
      s_d.level = (s_q.st == ST_ON) ? 8'hff :
         (s_q.st == ST_RAMP_UP) ? 8'(({s_q.ms_cnt, 8'd0} / {8'd0, half_d}) & 21'hff) :
         (s_q.st == ST_RAMP_DN) ? 8'(8'hff - 8'(({s_q.ms_cnt, 8'd0} / {8'd0, half_d}) & 21'hff)) :
         8'h00;
      if (cfg.mode != BH_PULSE1 && stop_ev)
         s_d.releasing = 1'b1;
      case (s_q.st)
         ST_IDLE:
         begin
            if (enable && start_ev)
            begin
               s_d.ms_cnt = '0;
               s_d.pulses = '0;
               s_d.releasing = 1'b0;
               s_d.st = (cfg.mode == BH_DIRECT) ? ST_ON : ST_RAMP_UP;
            end
         end
         ST_ON:
         begin
            if (stop_ev || !enable)
            begin
               s_d.st = ST_IDLE;
               s_d.done = 1'b1;
            end
         end
         ST_RAMP_UP:
         begin
            if (s_q.ms_cnt >= half_d)
            begin
               s_d.ms_cnt = '0;
               s_d.st = ST_RAMP_DN;
            end
         end
         ST_RAMP_DN:
         begin
            if (s_q.ms_cnt >= half_d)
            begin
               s_d.ms_cnt = '0;
               s_d.st = ST_RAMP_UP;
               if (cfg.mode == BH_PULSE1)
               begin
                  s_d.pulses = s_q.pulses + 4'd1;
                  if (s_q.pulses >= {1'b0, cfg.p1_cnt})
                  begin
                     s_d.st = ST_IDLE;
                     s_d.done = 1'b1;
                  end
               end
               else if (cfg.mode == BH_PULSE2 && (s_q.releasing || stop_ev))
               begin
                  // Counting of trailing pulses begins at the release.
                  s_d.pulses = s_q.releasing ? s_q.pulses + 4'd1 : 4'd1;
                  s_d.releasing = 1'b1;
                  if (s_q.releasing && s_q.pulses >= {1'b0, cfg.p2_cnt})
                  begin
                     s_d.st = ST_IDLE;
                     s_d.done = 1'b1;
                  end
               end
               else if (cfg.mode == BH_BREATHE && (s_q.releasing || stop_ev))
               begin
                  s_d.st = ST_IDLE;
                  s_d.done = 1'b1;
               end
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
      if (!enable)
         s_d.st = ST_IDLE;
      // PWM comparator; level 0 stays fully off, 255 fully on.
      if (pwm_step)
         s_d.pwm_cnt = (s_q.pwm_cnt >= cfg.steps_m1) ? 8'h00 : s_q.pwm_cnt + 8'h01;
      s_d.led = (s_q.level == 8'hff) || (s_q.level != 8'h00 && s_q.pwm_cnt < s_q.level);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign led_out = s_q.led;
   assign done = s_q.done;
   assign busy = (s_q.st != ST_IDLE);
endmodule // lbpe_channel

// ==== lbpe_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Direct: on at touch, off at release.
// - Pulse 1: counted pulses, each one period.
// - Pulse 1 start edge chosen by bit 7.
// - Pulse 2: pulse, then counted pulses after release.
// - Breathe: ramp up, down, half period each.
// - Period field in 32 ms units, 0 as 1.
// - Pulse 1 period register resets to 20h.
// - Pulse 2 period register resets to 14h.
// - Breathe period register resets to 5Dh.
// - Pulse counts n give n plus one pulses.
// - Alert on drive-bit LED finishing when enabled.
// - Power LED uses sleep field while sleeping.
// - Two-bit behaviour fields, LED1 lowest.
// - PWM rate from steps and base clock; LED1 to LED10 use 256 steps at aclk.
// - Eleventh_led_pwm_config ignored unless custom enabled.
// - Eleventh_led_step_count: 256, 128, 64, 32.
// - Variable PWM bit selects frequency mode.
// - LED11 base clock select, spare codes 500 kHz.
// - Unlinked LED: drive bit acts as touch.
// - Start and stop triggers; inputs ignored.
// - Duty ramps between minimum and maximum.
module lbpe_top
   import lbpe_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Trigger sources.
   input wire logic [NUM_LED-1:0] touch_state,
   input wire logic [NUM_LED-1:0] sensor_linked,
   input wire logic [NUM_LED-1:0] output_drive_bit,
   input wire logic [NUM_LED-1:0] pin_is_input,
   input wire logic power_indicator_enable,
   input wire logic sleep_select,
   input wire logic deep_sleep_select,
   input wire logic eleventh_led_custom_enable,
   // Outputs.
   output logic [NUM_LED-1:0] led_drive,
   output logic alert
);
   import lbpe_pkg::*;

   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   typedef struct packed {
      logic [7:0] behav_low;
      logic [7:0] behav_mid;
      logic [7:0] behav_high;
      logic [7:0] p1_period;
      logic [7:0] p2_period;
      logic [7:0] br_period;
      logic [7:0] cnt_cfg;
      logic [7:0] l11_cfg;
      logic aw_got, w_got;
      logic [7:0] aw_idx;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] tick_cnt;
      logic tick;
      logic [8:0] base_cnt;
      logic [5:0] pre_cnt;
      logic pwm_step;
      logic [NUM_LED-1:0] by_drive;
      logic alert;
   } lbpe_top_s;

   lbpe_top_s s_q, s_d;

   logic [NUM_LED-1:0] actuate, ch_done, ch_busy, ch_led;
   lbpe_cfg_s cfg [NUM_LED];

   // Address to register index; only word-aligned hits decode.
   function automatic logic [7:0] to_idx(input logic [31:0] a);
      return (a[1:0] == 2'b00 && a[31:10] == '0) ? a[9:2] : 8'hff;
   endfunction

   function automatic logic known(input logic [7:0] i);
      return i inside {IDX_BEHAV_LOW, IDX_BEHAV_MID, IDX_BEHAV_HIGH, IDX_P1_PERIOD,
         IDX_P2_PERIOD, IDX_BR_PERIOD, IDX_CNT_CFG, IDX_L11_CFG, IDX_CTRL, IDX_STATUS};
   endfunction

   // ======================================================================
   // Channel configuration
   // ======================================================================
   // LED11 takes its sleep field while the power option is on and a sleep
   // state is selected, but a drive bit always uses the normal field.
   logic use_alt;
   logic [7:0] l11_eff;
   assign use_alt = power_indicator_enable && (sleep_select || deep_sleep_select)
      && !output_drive_bit[NUM_LED-1];
   assign l11_eff = eleventh_led_custom_enable ? s_q.l11_cfg : RST_L11_CFG;

   always_comb
   begin
      logic [23:0] all_fields;
      all_fields = {s_q.behav_high, s_q.behav_mid, s_q.behav_low};
      for (int i = 0; i < NUM_LED; i++)
      begin
         cfg[i].mode = lbpe_mode_e'(all_fields[2*i +: 2]);
         if (i == NUM_LED - 1 && use_alt)
            cfg[i].mode = lbpe_mode_e'(s_q.behav_high[7:6]);
         cfg[i].trig_on_release = s_q.p1_period[TRIG_SEL_BIT];
         cfg[i].pulse_one_period_field = s_q.p1_period[PER_W-1:0];
         cfg[i].pulse_two_period_field = s_q.p2_period[PER_W-1:0];
         cfg[i].breath_period_field = s_q.br_period[PER_W-1:0];
         cfg[i].p1_cnt = s_q.cnt_cfg[2:0];
         cfg[i].p2_cnt = s_q.cnt_cfg[5:3];
         cfg[i].steps_m1 = 8'hff;
         if (i == NUM_LED - 1)
            cfg[i].steps_m1 = 8'(9'h100 >> l11_eff[5:4]) - 8'h01;
      end
   end

   // Linked LEDs follow the sensor, others their drive bit.
   assign actuate = (sensor_linked & touch_state) | (~sensor_linked & output_drive_bit);

   // ======================================================================
   // Channels
   // ======================================================================
   for (genvar g = 0; g < NUM_LED; g++)
   begin : g_ch
      lbpe_channel u_ch (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick_ms(s_q.tick),
         .pwm_step((g == NUM_LED - 1) ? s_q.pwm_step : 1'b1),
         .cfg(cfg[g]),
         .actuate(actuate[g]),
         .enable(!pin_is_input[g]),
         .led_out(ch_led[g]),
         .done(ch_done[g]),
         .busy(ch_busy[g])
      );
   end

   // ======================================================================
   // Register file, timing and alert
   // ======================================================================
   always_comb
   begin
      logic [7:0] ridx;
      logic [5:0] pre_lim;
      pre_lim = 6'h00;
      ridx = to_idx(s_axi_araddr);
      s_d = s_q;
      // Free-running millisecond tick.
      s_d.tick = 1'b0;
      if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1))
      begin
         s_d.tick_cnt = '0;
         s_d.tick = 1'b1;
      end
      else
         s_d.tick_cnt = s_q.tick_cnt + 32'd1;
      // LED11 base clock: 500 kHz divided by 4, 8, 16, 32, 64.
      case (l11_eff[2:0])
         3'b001: pre_lim = 6'd3;
         3'b010: pre_lim = 6'd7;
         3'b011: pre_lim = 6'd15;
         3'b100: pre_lim = 6'd31;
         3'b101: pre_lim = 6'd63;
         default: pre_lim = 6'd0;
      endcase
      // Fixed mode steps at the base clock; variable mode adds one per tick.
      s_d.pwm_step = 1'b0;
      if (s_q.base_cnt >= 9'(BASE_DIV - 1))
      begin
         s_d.base_cnt = '0;
         if (s_q.pre_cnt >= pre_lim)
         begin
            s_d.pre_cnt = '0;
            s_d.pwm_step = 1'b1;
         end
         else
            s_d.pre_cnt = s_q.pre_cnt + 6'd1;
      end
      else
         s_d.base_cnt = s_q.base_cnt + 9'h001;
      if (l11_eff[VAR_PWM_BIT] && s_q.tick)
         s_d.pwm_step = 1'b1;
      // Mark LEDs started by drive bits.
      for (int i = 0; i < NUM_LED; i++)
         if (!ch_busy[i])
            s_d.by_drive[i] = !sensor_linked[i];
      // Write channel: address and data taken in either order.
      if (s_axi_awvalid && !s_q.aw_got)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_idx = to_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && !s_q.w_got)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb0 = s_axi_wstrb[0];
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = known(s_q.aw_idx) ? RESP_OK : RESP_ERR;
         if (s_q.wstrb0)
            case (s_q.aw_idx)
               IDX_BEHAV_LOW: s_d.behav_low = s_q.wdata[7:0];
               IDX_BEHAV_MID: s_d.behav_mid = s_q.wdata[7:0];
               IDX_BEHAV_HIGH: s_d.behav_high = s_q.wdata[7:0];
               IDX_P1_PERIOD: s_d.p1_period = s_q.wdata[7:0];
               IDX_P2_PERIOD: s_d.p2_period = {1'b0, s_q.wdata[6:0]};
               IDX_BR_PERIOD: s_d.br_period = {1'b0, s_q.wdata[6:0]};
               IDX_CNT_CFG: s_d.cnt_cfg = {1'b0, s_q.wdata[6:0]};
               IDX_L11_CFG: s_d.l11_cfg = {2'b00, s_q.wdata[5:0]};
               IDX_CTRL: if (s_q.wdata[0]) s_d.alert = 1'b0;
               default: ;
            endcase
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      // A new finish in the clearing cycle keeps the alert set.
      if (s_q.cnt_cfg[ALERT_EN_BIT] && |(ch_done & s_q.by_drive))
         s_d.alert = 1'b1;
      // Read channel: one cycle from address to data.
      if (s_axi_arvalid && !s_q.rvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = known(ridx) ? RESP_OK : RESP_ERR;
         case (ridx)
            IDX_BEHAV_LOW: s_d.rdata = {24'd0, s_q.behav_low};
            IDX_BEHAV_MID: s_d.rdata = {24'd0, s_q.behav_mid};
            IDX_BEHAV_HIGH: s_d.rdata = {24'd0, s_q.behav_high};
            IDX_P1_PERIOD: s_d.rdata = {24'd0, s_q.p1_period};
            IDX_P2_PERIOD: s_d.rdata = {24'd0, s_q.p2_period};
            IDX_BR_PERIOD: s_d.rdata = {24'd0, s_q.br_period};
            IDX_CNT_CFG: s_d.rdata = {24'd0, s_q.cnt_cfg};
            IDX_L11_CFG: s_d.rdata = {24'd0, s_q.l11_cfg};
            IDX_STATUS: s_d.rdata = {20'd0, s_q.alert, ch_busy};
            default: s_d.rdata = '0;
         endcase
      end
      else if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;
   end

   // Reset loads the documented register defaults.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.behav_low <= RST_BEHAV;
         s_q.behav_mid <= RST_BEHAV;
         s_q.behav_high <= RST_BEHAV;
         s_q.p1_period <= RST_P1_PERIOD;
         s_q.p2_period <= RST_P2_PERIOD;
         s_q.br_period <= RST_BR_PERIOD;
         s_q.cnt_cfg <= RST_CNT_CFG;
         s_q.l11_cfg <= RST_L11_CFG;
      end
      else
         s_q <= s_d;
   end

   // Ready signals are registered state, so outputs stay flop-driven.
   assign s_axi_awready = !s_q.aw_got;
   assign s_axi_wready = !s_q.w_got;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign led_drive = ch_led;
   assign alert = s_q.alert;
endmodule // lbpe_top

// ==== lbpe_top_props.sv ====
`timescale 1ns/10ps
// ======================================================================
// Port checker for the register bus, the alert and the idle pins.
module lbpe_top_props
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel pins.
   input wire logic [lbpe_pkg::NUM_LED-1:0] pin_is_input,
   input wire logic [lbpe_pkg::NUM_LED-1:0] led_drive,
   input wire logic alert
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // An answer that moves before it is taken hands software a wrong value.
   chk_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write answer moved early.");
   chk_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
      else $error("Read answer moved early.");
   chk_read_slot: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("Read address ready out of turn.");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late.");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("Write answer late.");
   chk_resp_code: assert property (
      (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0) and (s_axi_rvalid |-> s_axi_rresp[0] == 1'b0))
      else $error("Bad response code.");
   chk_alert_clear: assert property (
      $fell(alert) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("Alert dropped unasked.");
   chk_input_dark: assert property (
      (led_drive & pin_is_input & $past(pin_is_input) & $past(pin_is_input, 2)
      & $past(pin_is_input, 3)) == '0)
      else $error("Input channel lit.");
   cov_write: cover property (s_axi_bvalid && s_axi_bready);
   cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cov_alert: cover property ($rose(alert));
endmodule // lbpe_top_props

// ==== lbpe_led_load.sv ====
`timescale 1ns/10ps
// ======================================================================
// Touch sensors and LED loads; each load counts the cycles it is lit.
module lbpe_led_load
   import lbpe_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Finger and LED pins.
   input wire logic [lbpe_pkg::NUM_LED-1:0] press,
   input wire logic [lbpe_pkg::NUM_LED-1:0] led_drive,
   output logic [lbpe_pkg::NUM_LED-1:0] touch_state,
   output logic [lbpe_pkg::NUM_LED-1:0][15:0] lit_cnt
);
   // The sensed level lags the finger by one cycle, as a sampled sensor does.
   always_ff @(posedge aclk)
   begin
      touch_state <= aresetn ? press : '0;
      for (int i = 0; i < NUM_LED; i++)
      begin
         if (!aresetn) lit_cnt[i] <= 16'h0;
         else if (led_drive[i]) lit_cnt[i] <= lit_cnt[i] + 16'h1;
      end
   end
endmodule // lbpe_led_load

// ==== lbpe_top_bench.sv ====
`timescale 1ns/10ps
// ======================================================================
// Self-checking bench: registers, behaviours, alert and power LED.
module lbpe_top_bench;
   import lbpe_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [NUM_LED-1:0] touch_state, sensor_linked, output_drive_bit, pin_is_input, press;
   logic [NUM_LED-1:0] led_drive;
   logic [NUM_LED-1:0][15:0] lit_cnt;
   logic power_indicator_enable, sleep_select, deep_sleep_select, eleventh_led_custom_enable;
   logic alert;
   int mismatches, tests_run, cycles;
   // A short tick keeps one 32 ms unit at 128 cycles.
   lbpe_top #(.TICK_CYCLES(4)) dut_u (.*);
   lbpe_led_load load_u (.*);
   // Clock and hang guard.
   always #2.5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Maps an in-window value onto the low bound so one compare covers a range.
   function automatic int rng(input int t, input int lo, input int hi);
      return (t >= lo && t <= hi) ? lo : t;
   endfunction
   task automatic axw(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] idx);
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      {rd, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   // Holds a drive bit, notes when alert rises during and after it, then clears alert.
   task automatic act(input int ch, input int hold, output int t_h, output int t_r);
      t_h = -1;
      t_r = -1;
      @(posedge aclk);
      output_drive_bit[ch] <= 1'b1;
      for (int i = 0; i < hold; i++)
      begin
         @(posedge aclk);
         if (t_h < 0 && alert === 1'b1) t_h = i;
      end
      output_drive_bit[ch] <= 1'b0;
      for (int i = 0; i < 600 && t_r < 0 && t_h < 0; i++)
      begin
         @(posedge aclk);
         if (alert === 1'b1) t_r = i;
      end
      axw(IDX_CTRL, 8'h01);
      axr(IDX_STATUS);
      chk(rd[11], 1'b0);
   endtask
   task automatic t_regs();
      logic [7:0] idx [8] = '{IDX_BEHAV_LOW, IDX_BEHAV_MID, IDX_BEHAV_HIGH, IDX_P1_PERIOD,
         IDX_P2_PERIOD, IDX_BR_PERIOD, IDX_CNT_CFG, IDX_L11_CFG};
      logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h14, 8'h5d, 8'h24, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         axr(idx[i]);
         chk({rd, 2'h0, rsp}, {24'h0, rst[i], 4'h0});
      end
      axr(8'h87);
      chk({rd, 2'h0, rsp}, 36'h2);
      axw(8'h87, 8'h11);
      chk(rsp, 2'h2);
      axw(IDX_L11_CFG, 8'h3f);
      axr(IDX_L11_CFG);
      chk(rd, 32'h3f);
   endtask
   task automatic t_direct();
      logic [15:0] b;
      @(posedge aclk);
      {sensor_linked, press} <= {11'h002, 11'h002};
      // Input pin keeps Direct in its field, as software should.
      {pin_is_input, output_drive_bit} <= {11'h010, 11'h010};
      repeat (200) @(posedge aclk);
      chk(rng(lit_cnt[1], 150, 200), 150);
      chk(lit_cnt[4], 16'h0);
      {press, output_drive_bit, pin_is_input} <= '0;
      repeat (50) @(posedge aclk);
      b = lit_cnt[1];
      repeat (100) @(posedge aclk);
      chk(lit_cnt[1], b);
      sensor_linked <= '0;
   endtask
   task automatic t_pulse1();
      int th, tr;
      axw(IDX_BEHAV_LOW, 8'h01);
      axw(IDX_P1_PERIOD, 8'h00);
      axw(IDX_CNT_CFG, 8'h41);
      act(0, 300, th, tr);
      chk(rng(th, 248, 272), 248);
      axw(IDX_P1_PERIOD, 8'h02);
      axw(IDX_CNT_CFG, 8'h42);
      act(0, 820, th, tr);
      chk(rng(th, 760, 784), 760);
      axw(IDX_CNT_CFG, 8'h02);
      act(0, 820, th, tr);
      chk(th, -1);
      axw(IDX_P1_PERIOD, 8'h81);
      axw(IDX_CNT_CFG, 8'h40);
      act(0, 200, th, tr);
      chk(th, -1);
      chk(rng(tr, 120, 144), 120);
   endtask
   task automatic t_modes();
      int th, tr;
      axw(IDX_P2_PERIOD, 8'h01);
      axw(IDX_BR_PERIOD, 8'h01);
      axw(IDX_CNT_CFG, 8'h48);
      axw(IDX_BEHAV_LOW, 8'h20);
      act(2, 300, th, tr);
      chk(th, -1);
      chk(rng(tr, 120, 400), 120);
      axw(IDX_BEHAV_LOW, 8'hc0);
      act(3, 300, th, tr);
      chk(th, -1);
      chk(rng(tr, 0, 144), 0);
   endtask
   task automatic t_power();
      int th, tr;
      logic [1:0] s [3] = '{2'b01, 2'b10, 2'b00};
      logic e [3] = '{1'b0, 1'b0, 1'b1};
      axw(IDX_BEHAV_HIGH, 8'h40);
      axw(IDX_P1_PERIOD, 8'h01);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge aclk);
         {sleep_select, deep_sleep_select, sensor_linked[10], press[10]} <= {s[i], 2'h3};
         {power_indicator_enable, eleventh_led_custom_enable} <= {1'b1, s[i][0]};
         repeat (200) @(posedge aclk);
         axr(IDX_STATUS);
         chk(rd[10], e[i]);
         {sensor_linked[10], press[10]} <= 2'h0;
         act(10, 40, th, tr);
         chk(rng(tr, 0, 8), 0);
      end
   endtask
   // Main sequence.
   initial
   begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'h1;
      {sensor_linked, output_drive_bit, pin_is_input, press} = '0;
      {power_indicator_enable, sleep_select, deep_sleep_select} = '0;
      eleventh_led_custom_enable = 1'b0;
      {mismatches, tests_run, cycles} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_direct();
      t_pulse1();
      t_modes();
      t_power();
      finish_test();
   end
endmodule // lbpe_top_bench
bind lbpe_top lbpe_top_props chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_is_input,
   .led_drive, .alert);
